// ---- capture_pkg.sv ----
package capture_pkg;
   // ==========================================================================
   // register map (word aligned byte addresses)
   // ==========================================================================
   localparam logic [4:0]  CTRL_OFFS       = 5'h00; // w: begin/halt command
   localparam logic [4:0]  LEN_OFFS        = 5'h04; // rw: buffer length in kbytes
   localparam logic [4:0]  CFG_OFFS        = 5'h08; // rw: channel set
   localparam logic [4:0]  RATE_OFFS       = 5'h0C; // rw: rate divider
   localparam logic [4:0]  STATE_OFFS      = 5'h10; // r: state word
   localparam logic [4:0]  BYTES_OFFS      = 5'h14; // r: captured bytes
   localparam logic [4:0]  PROG_OFFS       = 5'h18; // r: kbyte progress
   localparam logic [4:0]  SAMPLE_OFFS     = 5'h1C; // r: last sample written
   // ctrl fields
   localparam int          CTRL_BEGIN_BIT  = 0;
   localparam int          CTRL_HALT_BIT   = 1;
   localparam int          CTRL_RING_BIT   = 4;
   localparam int          CTRL_MODE_LSB   = 8;
   // settings
   localparam logic [12:0] LEN_MAX         = 13'h1000;
   localparam logic [12:0] LEN_RST         = 13'h0100;
   localparam logic [4:0]  RATE_MAX        = 5'h14;
   localparam logic [1:0]  MODE_IMMEDIATE  = 2'h0;
   localparam logic [1:0]  MODE_TRIG       = 2'h1;
   localparam logic [1:0]  MODE_PER_TRIG   = 2'h2;
   // buffer geometry
   localparam int          BLOCK_BYTES     = 2048;
   localparam int          WORD_BYTES      = 4;
   localparam int          ADDR_W          = 20;   // 4 Mbyte / 4 bytes
   localparam int          BYTES_W         = 23;
   localparam logic [8:0]  BLOCK_LAST_WORD = 9'h1FF;
   // state word bits
   localparam int          ST_BUSY_BIT     = 0;
   localparam int          ST_STARTED_BIT  = 1;
   localparam int          ST_WRAP_BIT     = 2;
endpackage : capture_pkg

// ---- capture_buffer.sv ----
// Decided for this implementation: the register offsets and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
module capture_buffer (
   input  wire logic        i_mclk,          // 200 MHz clock
   input  wire logic        i_rst_b,         // sync reset, active low
   input  wire logic        i_ce,            // clock enable
   input  wire logic [4:0]  avs_address,     // byte address
   input  wire logic        avs_read,        // read request
   input  wire logic        avs_write,       // write request
   input  wire logic [31:0] avs_writedata,   // write data
   input  wire logic [3:0]  avs_byteenable,  // byte lanes
   output logic [31:0]      avs_readdata,    // read data
   output logic             avs_waitrequest, // stall
   input  wire logic        i_sample_tick,   // peak-rate sample strobe
   input  wire logic [31:0] i_x,             // x value, float
   input  wire logic [31:0] i_y,             // y value, float
   input  wire logic [31:0] i_r,             // r value, float
   input  wire logic [31:0] i_theta,         // theta value, float
   input  wire logic        i_ext_trig,      // external trigger input
   input  wire logic [19:0] i_rd_addr,       // buffer readout word address
   output logic [31:0]      o_rd_data        // buffer readout word
);
   // ==========================================================================
   // types and storage
   // ==========================================================================
   typedef enum logic [4:0] {
      S_IDLE = 5'b00001,
      S_WAIT = 5'b00010,
      S_RUN  = 5'b00100,
      S_FILL = 5'b01000,
      S_DONE = 5'b10000
   } cap_state_type;

   localparam int DEPTH = 1 << capture_pkg::ADDR_W;

   logic [31:0]                     mem [DEPTH];
   cap_state_type                   state_r, state_nxt;
   logic [12:0]                     len_r;
   logic [1:0]                      cfg_r;
   logic [4:0]                      rate_r;
   logic                            ring_r;
   logic [1:0]                      mode_r;
   logic                            started_r, wrap_r;
   logic [capture_pkg::ADDR_W-1:0]  waddr_r;
   logic [capture_pkg::BYTES_W-1:0] bytes_r;
   logic [12:0]                     prog_r;
   logic [1:0]                      ch_r;
   logic                            burst_r;
   logic [19:0]                     div_r;
   logic [31:0]                     ch_val [4];
   logic [31:0]                     last_r;
   logic                            trig_s1_r, trig_s2_r, trig_d_r;
   logic                            rd_pend_r;
   logic [31:0]                     rdata_r;
   logic                            stop_pend_r;
   logic [31:0]                     hold_r [4];

   // ==========================================================================
   // helpers
   // ==========================================================================
   function automatic logic [12:0] even_len(input logic [12:0] n);
      logic [12:0] v;
      v = (n == 13'h0000) ? 13'h0001 : ((n > capture_pkg::LEN_MAX) ? capture_pkg::LEN_MAX : n);
      return v + {12'h000, v[0]};
   endfunction

   function automatic logic [1:0] ch_count_m1(input logic [1:0] c);
      return (c == 2'h0) ? 2'h0 : ((c == 2'h3) ? 2'h3 : 2'h1);
   endfunction

   // ==========================================================================
   // bus decode
   // ==========================================================================
   wire wr_ctrl   = i_ce && avs_write && avs_address == capture_pkg::CTRL_OFFS && avs_byteenable[0];
   wire begin_cmd = wr_ctrl && avs_writedata[capture_pkg::CTRL_BEGIN_BIT];
   wire halt_cmd  = wr_ctrl && avs_writedata[capture_pkg::CTRL_HALT_BIT] && !begin_cmd;
   wire wr_len    = i_ce && avs_write && avs_address == capture_pkg::LEN_OFFS && avs_byteenable[1:0] == 2'h3;
   wire wr_cfg    = i_ce && avs_write && avs_address == capture_pkg::CFG_OFFS && avs_byteenable[0];
   wire wr_rate   = i_ce && avs_write && avs_address == capture_pkg::RATE_OFFS && avs_byteenable[0];
   wire [1:0] mode_in = avs_writedata[capture_pkg::CTRL_MODE_LSB +: 2];
   wire mode_ok   = mode_in != 2'h3;
   wire begin_ok  = begin_cmd && mode_ok;
   wire sys_clear = begin_ok || wr_len || wr_cfg;

   // ==========================================================================
   // trigger synchroniser and edge detect
   // ==========================================================================
   wire trig_fall = trig_d_r && !trig_s2_r;

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         trig_s1_r <= 1'b1;
         trig_s2_r <= 1'b1;
         trig_d_r  <= 1'b1;
      end else if (i_ce) begin
         trig_s1_r <= i_ext_trig;
         trig_s2_r <= trig_s1_r;
         trig_d_r  <= trig_s2_r;
      end
   end

   // ==========================================================================
   // rate divider: a sample instant every 2^rate peak ticks
   // ==========================================================================
   wire [19:0] div_mask  = 20'(({21'h000001} << rate_r) - 21'h000001);
   wire        rate_hit  = i_sample_tick && ((div_r & div_mask) == 20'h00000);
   wire        instant   = !burst_r && state_r == S_RUN &&
                           ((mode_r == capture_pkg::MODE_PER_TRIG) ? trig_fall : rate_hit);

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b)
         div_r <= 20'h00000;
      else if (i_ce && (begin_ok || state_r != S_RUN))
         div_r <= 20'h00000;
      else if (i_ce && i_sample_tick)
         div_r <= div_r + 20'h00001;
   end

   // ==========================================================================
   // write path
   // ==========================================================================
   wire [capture_pkg::ADDR_W-1:0] last_word = 20'({len_r, 8'h00} - 21'h000001);
   wire at_end      = waddr_r == last_word;
   wire blk_end     = waddr_r[8:0] == capture_pkg::BLOCK_LAST_WORD;
   wire trig_stop   = state_r == S_RUN && ring_r && mode_r == capture_pkg::MODE_TRIG && trig_fall;
   wire stop_req    = halt_cmd || trig_stop || stop_pend_r;
   // a stop outranks a new sample instant, so the stop cycle never starts a unit
   wire write_data  = (state_r == S_RUN) && (burst_r || (instant && !stop_req));
   wire write_zero  = state_r == S_FILL;
   wire do_write    = write_data || write_zero;
   wire unit_last   = ch_r == ch_count_m1(cfg_r);
   wire full_stop   = write_data && at_end && !ring_r;
   wire halt_run    = state_r == S_RUN && stop_req && !burst_r;
   wire blk_done    = write_zero && (blk_end || at_end);
   wire ring_wrap   = write_data && at_end && ring_r;
   wire [1:0] sel   = (cfg_r == 2'h2) ? ch_r + 2'h2 : ch_r;
   // the first word of a unit comes live, the rest from the values held at that instant
   wire [31:0] data_word = burst_r ? hold_r[sel] : ch_val[sel];

   assign ch_val[0] = i_x;
   assign ch_val[1] = i_y;
   assign ch_val[2] = i_r;
   assign ch_val[3] = i_theta;

   always_ff @(posedge i_mclk) begin
      if (i_ce && write_data && !burst_r) begin
         for (int k = 0; k < 4; k++)
            hold_r[k] <= ch_val[k];
      end
   end

   // a stop that lands inside a multi-word unit waits here until the unit is complete
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b)
         stop_pend_r <= 1'b0;
      else if (i_ce && (begin_ok || state_r != S_RUN))
         stop_pend_r <= 1'b0;
      else if (i_ce && (halt_cmd || trig_stop))
         stop_pend_r <= 1'b1;
   end

   always_ff @(posedge i_mclk) begin
      if (i_ce && do_write)
         mem[waddr_r] <= write_zero ? 32'h00000000 : data_word;
   end

   always_ff @(posedge i_mclk) begin
      if (i_ce)
         o_rd_data <= mem[i_rd_addr];
   end

   // ==========================================================================
   // acquisition state machine
   // ==========================================================================
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         S_IDLE, S_DONE: state_nxt = state_r;
         S_WAIT: begin
            if (halt_cmd)
               state_nxt = S_IDLE;
            else if (trig_fall)
               state_nxt = S_RUN;
         end
         S_RUN: begin
            if (full_stop)
               state_nxt = S_DONE;
            else if (halt_run)
               state_nxt = (waddr_r[8:0] == 9'h000) ? S_DONE : S_FILL;
         end
         S_FILL: begin
            if (blk_done)
               state_nxt = S_DONE;
         end
      endcase
      if (begin_ok)
         state_nxt = (mode_in == capture_pkg::MODE_TRIG && !avs_writedata[capture_pkg::CTRL_RING_BIT])
                     ? S_WAIT : S_RUN;
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b)
         state_r <= S_IDLE;
      else if (i_ce)
         state_r <= state_nxt;
   end

   // ==========================================================================
   // pointers and counts
   // ==========================================================================
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         waddr_r <= '0;
         bytes_r <= '0;
         prog_r  <= 13'h0000;
         ch_r    <= 2'h0;
         burst_r <= 1'b0;
      end else if (i_ce) begin
         if (begin_ok) begin
            waddr_r <= '0;
            bytes_r <= '0;
            prog_r  <= 13'h0000;
            ch_r    <= 2'h0;
            burst_r <= 1'b0;
         end else if (do_write) begin
            waddr_r <= (at_end) ? '0 : waddr_r + 20'h00001;
            if (write_data) begin
               ch_r    <= unit_last ? 2'h0 : ch_r + 2'h1;
               burst_r <= !unit_last;
               if (wrap_r && ring_r && waddr_r[8:0] == 9'h000)
                  bytes_r <= bytes_r - 23'(capture_pkg::BLOCK_BYTES - capture_pkg::WORD_BYTES);
               else
                  bytes_r <= bytes_r + 23'(capture_pkg::WORD_BYTES);
            end
            if ((blk_end || at_end) && !wrap_r)
               prog_r <= prog_r + 13'h0002;
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         started_r <= 1'b0;
         wrap_r    <= 1'b0;
      end else if (i_ce) begin
         if (sys_clear) begin
            started_r <= begin_ok && !(mode_in == capture_pkg::MODE_TRIG && !avs_writedata[capture_pkg::CTRL_RING_BIT]);
            wrap_r    <= 1'b0;
         end else begin
            if (state_r == S_WAIT && trig_fall && !halt_cmd)
               started_r <= 1'b1;
            if (full_stop || ring_wrap)
               wrap_r <= 1'b1;
         end
      end
   end

   // ==========================================================================
   // settings
   // ==========================================================================
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         len_r  <= capture_pkg::LEN_RST;
         cfg_r  <= 2'h0;
         rate_r <= 5'h00;
         ring_r <= 1'b0;
         mode_r <= capture_pkg::MODE_IMMEDIATE;
      end else if (i_ce) begin
         if (wr_len)
            len_r <= even_len(avs_writedata[12:0]);
         if (wr_cfg)
            cfg_r <= avs_writedata[1:0];
         if (wr_rate)
            rate_r <= (avs_writedata[4:0] > capture_pkg::RATE_MAX) ? capture_pkg::RATE_MAX : avs_writedata[4:0];
         if (begin_ok) begin
            ring_r <= avs_writedata[capture_pkg::CTRL_RING_BIT];
            mode_r <= mode_in;
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b)
         last_r <= 32'h00000000;
      else if (i_ce && write_data)
         last_r <= data_word;
   end

   // ==========================================================================
   // bus read: one wait cycle
   // ==========================================================================
   wire       busy       = state_r == S_RUN || state_r == S_FILL;
   wire [2:0] state_word = {wrap_r, started_r, busy};
   wire [12:0] prog_val  = (wrap_r && ring_r) ? len_r : prog_r;
   logic [31:0] rd_mux;

   always_comb begin
      unique case (avs_address)
         capture_pkg::LEN_OFFS:    rd_mux = {19'h00000, len_r};
         capture_pkg::CFG_OFFS:    rd_mux = {30'h00000000, cfg_r};
         capture_pkg::RATE_OFFS:   rd_mux = {27'h0000000, rate_r};
         capture_pkg::STATE_OFFS:  rd_mux = {29'h00000000, state_word};
         capture_pkg::BYTES_OFFS:  rd_mux = {9'h000, bytes_r};
         capture_pkg::PROG_OFFS:   rd_mux = {19'h00000, prog_val};
         capture_pkg::SAMPLE_OFFS: rd_mux = last_r;
         default:                  rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         rd_pend_r <= 1'b0;
         rdata_r   <= 32'h00000000;
      end else if (i_ce) begin
         rd_pend_r <= avs_read && !rd_pend_r;
         rdata_r   <= rd_mux;
      end
   end

   assign avs_waitrequest = avs_read && !rd_pend_r;
   assign avs_readdata    = rdata_r;

   // ==========================================================================
   // checks
   // ==========================================================================
   AST_WAIT_ZERO: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      state_r == S_WAIT |-> state_word == 3'h0) else $error("state word not zero while waiting");
   AST_TRIG_START: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      i_ce && state_r == S_WAIT && trig_fall && !halt_cmd && !sys_clear |=> state_word == 3'h3)
      else $error("trigger did not start capture");
   AST_HALT_WAIT: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      i_ce && state_r == S_WAIT && halt_cmd && !begin_ok |=> state_r == S_IDLE) else $error("halt did not abort");
   AST_DONE_HOLD: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      state_r == S_DONE && !sys_clear && !wr_len |=> $stable(bytes_r) && $stable(wrap_r) && state_r == S_DONE)
      else $error("halt after end changed state");
   AST_LEN_EVEN: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      !len_r[0] && len_r != 13'h0000 && len_r <= capture_pkg::LEN_MAX) else $error("bad length");
   AST_FILL_ZERO: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      state_r == S_FILL && i_ce |-> !write_data && busy) else $error("fill wrote data");
   AST_FULL_WRAP: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      i_ce && full_stop && !sys_clear |=> wrap_r && state_r == S_DONE) else $error("full did not wrap");
   AST_STICKY: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      $past(started_r) && !$past(sys_clear) |-> started_r) else $error("started bit dropped");
   AST_RING_DROP: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      i_ce && write_data && wrap_r && ring_r && waddr_r[8:0] == 9'h000 && !sys_clear
      |=> bytes_r == $past(bytes_r) - 23'h0007FC) else $error("ring count drop wrong");
   COV_TRIG: cover property (@(posedge i_mclk) state_r == S_WAIT ##1 state_r == S_RUN);
   COV_FILL: cover property (@(posedge i_mclk) state_r == S_FILL ##1 state_r == S_DONE);
   AST_UNIT_START: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      i_ce && write_data && !burst_r && cfg_r == 2'h3 && !sys_clear |=> burst_r && ch_r == 2'h1)
      else $error("unit did not go on with its second value");
   COV_RING: cover property (@(posedge i_mclk) ring_wrap);
   COV_UNIT: cover property (@(posedge i_mclk) write_data && burst_r && ch_r == 2'h3);
endmodule // capture_buffer
`default_nettype wire

// ---- capture_partner.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// far side: peak-rate sample strobe and external trigger line
// ==========================================================================
module capture_partner (
   input  wire logic i_mclk,    // system clock
   input  wire logic i_tick_en, // run the sample strobe
   input  wire logic i_fall,    // request one trigger pulse
   output logic      o_tick,    // sample strobe
   output logic      o_trig     // trigger line, pulled high when idle
);
   initial begin
      o_tick = 1'b0;
      o_trig = 1'b1;
   end
   always @(posedge i_mclk) begin
      o_tick <= i_tick_en;
   end
   // low for four cycles, then back to the pull-up level
   always @(posedge i_mclk) begin
      if (i_fall) begin
         o_trig <= 1'b0;
         repeat (4) @(posedge i_mclk);
         o_trig <= 1'b1;
      end
   end
endmodule // capture_partner
`default_nettype wire

// ---- capture_buffer_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module capture_buffer_tb;
   logic        i_mclk = 1'b0;
   logic        i_rst_b = 1'b0;
   logic [4:0]  avs_address = 5'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        tick_en = 1'b0;
   logic        trig_req = 1'b0;
   logic        tick;
   logic        trig;
   logic [31:0] i_x = 32'h0;
   logic [31:0] i_y = 32'h0;
   logic [19:0] i_rd_addr = 20'h0;
   logic [31:0] o_rd_data;
   logic [31:0] seed = 32'h58;
   logic [31:0] rnd = 32'h58;
   logic [31:0] v;
   logic [31:0] w [4];
   int          n_fail = 0;
   int          n_compared = 0;
   int          n;
   always #2.5 i_mclk = ~i_mclk;
   capture_buffer i_dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_ce(1'b1), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .i_sample_tick(tick), .i_x(i_x),
      .i_y(i_y), .i_r(~i_x), .i_theta(~i_y), .i_ext_trig(trig), .i_rd_addr(i_rd_addr), .o_rd_data(o_rd_data));
   capture_partner i_far (.i_mclk(i_mclk), .i_tick_en(tick_en), .i_fall(trig_req), .o_tick(tick), .o_trig(trig));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   always @(posedge i_mclk) begin
      seed <= xs(seed);
      i_x  <= seed;
      i_y  <= {seed[15:0], seed[31:16]};
   end
   // ==========================================================================
   // bus cycles and comparisons
   // ==========================================================================
   task automatic cyc(input int c);
      repeat (c) @(posedge i_mclk);
   endtask
   task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= 1'b1;
      @(posedge i_mclk);
      while (avs_waitrequest !== 1'b0) @(posedge i_mclk);
      avs_write <= 1'b0;
      @(posedge i_mclk);
   endtask
   task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
      avs_address <= a;
      avs_read    <= 1'b1;
      @(posedge i_mclk);
      while (avs_waitrequest !== 1'b0) @(posedge i_mclk);
      d = avs_readdata;
      avs_read <= 1'b0;
      @(posedge i_mclk);
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_reg(input string what, input logic [4:0] a, input logic [31:0] exp);
      bus_rd(a, v);
      chk(what, exp, v);
   endtask
   task automatic mem_rd(input logic [19:0] a, output logic [31:0] d);
      i_rd_addr <= a;
      cyc(2);
      d = o_rd_data;
   endtask
   task automatic fall();
      trig_req <= 1'b1;
      @(posedge i_mclk);
      trig_req <= 1'b0;
      cyc(11);
   endtask
   task automatic wait_idle();
      int k;
      k = 0;
      bus_rd(capture_pkg::STATE_OFFS, v);
      while (v[capture_pkg::ST_BUSY_BIT] !== 1'b0 && k < 2000) begin
         bus_rd(capture_pkg::STATE_OFFS, v);
         k++;
      end
      chk("busy clears", 32'h0, {31'h0, v[capture_pkg::ST_BUSY_BIT]});
   endtask
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      // about 40000 cycles, several times the length of a clean run
      #200_000;
      n_fail++;
      give_verdict();
   end
   // ==========================================================================
   // scenarios
   // ==========================================================================
   initial begin
      cyc(6);
      i_rst_b <= 1'b1;
      @(posedge i_mclk);
      chk_reg("len reset", capture_pkg::LEN_OFFS, 32'h100);
      chk_reg("state reset", capture_pkg::STATE_OFFS, 32'h0);
      bus_wr(capture_pkg::LEN_OFFS, 32'h3);
      chk_reg("len odd", capture_pkg::LEN_OFFS, 32'h4);
      bus_wr(capture_pkg::LEN_OFFS, 32'h1388);
      chk_reg("len max", capture_pkg::LEN_OFFS, 32'h1000);
      bus_wr(capture_pkg::RATE_OFFS, 32'h19);
      chk_reg("rate max", capture_pkg::RATE_OFFS, 32'h14);
      for (int c = 3; c >= 0; c--) begin
         bus_wr(capture_pkg::CFG_OFFS, c);
         chk_reg("cfg", capture_pkg::CFG_OFFS, c);
      end
      bus_wr(capture_pkg::LEN_OFFS, 32'h2);
      bus_wr(capture_pkg::RATE_OFFS, 32'h0);
      tick_en <= 1'b1;
      bus_wr(capture_pkg::CTRL_OFFS, 32'h1);
      chk_reg("imm start", capture_pkg::STATE_OFFS, 32'h3);
      wait_idle();
      chk_reg("fill state", capture_pkg::STATE_OFFS, 32'h6);
      chk_reg("fill bytes", capture_pkg::BYTES_OFFS, 32'h800);
      chk_reg("fill prog", capture_pkg::PROG_OFFS, 32'h2);
      bus_wr(capture_pkg::CTRL_OFFS, 32'h2);
      chk_reg("late halt", capture_pkg::STATE_OFFS, 32'h6);
      chk_reg("late halt bytes", capture_pkg::BYTES_OFFS, 32'h800);
      bus_wr(capture_pkg::CFG_OFFS, 32'h0);
      chk_reg("sticky clear", capture_pkg::STATE_OFFS, 32'h0);
      bus_wr(capture_pkg::LEN_OFFS, 32'h4);
      rnd = xs(rnd);
      bus_wr(capture_pkg::CTRL_OFFS, 32'h1);
      cyc(20 + rnd % 200);
      tick_en <= 1'b0;
      bus_wr(capture_pkg::CTRL_OFFS, 32'h2);
      wait_idle();
      chk_reg("halt state", capture_pkg::STATE_OFFS, 32'h2);
      bus_rd(capture_pkg::BYTES_OFFS, v);
      chk("halt bytes ok", 32'h1, {31'h0, v > 0 && v < 2048 && v % 4 == 0});
      n = v / 4;
      mem_rd(n[19:0], v);
      chk("zero fill first", 32'h0, v);
      mem_rd(20'h1FF, v);
      chk("zero fill last", 32'h0, v);
      chk_reg("halt prog", capture_pkg::PROG_OFFS, 32'h2);
      bus_wr(capture_pkg::LEN_OFFS, 32'h2);
      tick_en <= 1'b1;
      bus_wr(capture_pkg::CTRL_OFFS, 32'h11);
      cyc(1300);
      bus_wr(capture_pkg::CTRL_OFFS, 32'h2);
      wait_idle();
      chk_reg("ring wrap", capture_pkg::STATE_OFFS, 32'h6);
      chk_reg("ring prog", capture_pkg::PROG_OFFS, 32'h2);
      bus_wr(capture_pkg::CTRL_OFFS, 32'h101);
      cyc(20);
      chk_reg("trig wait", capture_pkg::STATE_OFFS, 32'h0);
      fall();
      chk_reg("trig start", capture_pkg::STATE_OFFS, 32'h3);
      fall();
      chk_reg("trig no stop", capture_pkg::STATE_OFFS, 32'h3);
      bus_wr(capture_pkg::CTRL_OFFS, 32'h2);
      wait_idle();
      bus_wr(capture_pkg::CTRL_OFFS, 32'h101);
      bus_wr(capture_pkg::CTRL_OFFS, 32'h2);
      fall();
      chk_reg("abort state", capture_pkg::STATE_OFFS, 32'h0);
      chk_reg("fresh bytes", capture_pkg::BYTES_OFFS, 32'h0);
      bus_wr(capture_pkg::CTRL_OFFS, 32'h111);
      chk_reg("ring trig run", capture_pkg::STATE_OFFS, 32'h3);
      cyc(50);
      fall();
      wait_idle();
      chk_reg("ring trig stop", capture_pkg::STATE_OFFS, 32'h2);
      bus_wr(capture_pkg::CFG_OFFS, 32'h3);
      bus_wr(capture_pkg::RATE_OFFS, 32'h5);
      bus_wr(capture_pkg::CTRL_OFFS, 32'h201);
      rnd = xs(rnd);
      n = 3 + rnd % 4;
      repeat (n) fall();
      bus_wr(capture_pkg::CTRL_OFFS, 32'h2);
      wait_idle();
      chk_reg("per trig bytes", capture_pkg::BYTES_OFFS, n * 16);
      for (int k = 0; k < 4; k++) begin
         mem_rd(20'(k), w[k]);
      end
      chk("unit y", {w[0][15:0], w[0][31:16]}, w[1]);
      chk("unit r", ~w[0], w[2]);
      chk("unit theta", ~w[1], w[3]);
      mem_rd(20'(n * 4 - 1), v);
      chk_reg("last sample", capture_pkg::SAMPLE_OFFS, v);
      bus_wr(capture_pkg::CTRL_OFFS, 32'h301);
      chk_reg("mode 3 refused", capture_pkg::STATE_OFFS, 32'h2);
      bus_wr(capture_pkg::CFG_OFFS, 32'h0);
      bus_wr(capture_pkg::LEN_OFFS, 32'h4);
      for (int r = 0; r < 3; r++) begin
         bus_wr(capture_pkg::RATE_OFFS, r);
         tick_en <= 1'b1;
         bus_wr(capture_pkg::CTRL_OFFS, 32'h1);
         cyc(200);
         tick_en <= 1'b0;
         bus_wr(capture_pkg::CTRL_OFFS, 32'h2);
         wait_idle();
         bus_rd(capture_pkg::BYTES_OFFS, v);
         n = 800 >> r;
         chk("rate bytes", 32'h1, {31'h0, v + 24 >= n && v <= n + 24});
      end
      give_verdict();
   end
endmodule // capture_buffer_tb
`default_nettype wire
